// file: logic/bus_pattern_match.sv
/*
 * Compares one observed bus cycle with a match pattern and reports the
 * address, data and cycle status comparisons separately.
 * Assumes the pattern is stable register state on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module bus_pattern_match (
   // Pattern and observed cycle.
   input  wire trace_pkg::match_pattern_type pattern,
   input  wire trace_pkg::bus_cycle_type     cycle,
   // Comparison results.
   output logic                              addr_hit,
   output logic                              data_eq,
   output logic                              data_hit,
   output logic                              status_hit
);
   import trace_pkg::*;

   always_comb begin
      addr_hit   = !pattern.addr_en || (cycle.addr == pattern.addr);
      data_eq    = (cycle.data == pattern.data);
      data_hit   = !pattern.data_en || data_eq;
      status_hit = ((cycle.status ^ pattern.status) & pattern.care) == 4'h0;
   end

endmodule

`default_nettype wire

// file: logic/bus_trace_trigger_snapshot.sv
/*
 * Bus cycle trace with trigger, pass counter, trace qualifier, snapshot
 * partitioning of a 1024 entry trace memory and emulation break, with an APB
 * register file and one level interrupt.
 * Assumes the observed target bus pins hold address, data and status stable
 * while the cycle strobe is high, and that each strobe pulse spans at least
 * two pclk periods.
 */
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module bus_trace_trigger_snapshot #(
   parameter logic [3:0] FETCH1_CODE = 4'hC,
   parameter logic [3:0] BLK_CUT     = trace_pkg::BLOCK_MOVE_CUT
) (
   // Clock and reset.
   input  wire  logic                     pclk,
   input  wire  logic                     presetn,
   // APB slave.
   input  wire  logic                     psel,
   input  wire  logic                     penable,
   input  wire  logic                     pwrite,
   input  wire  logic [7:0]               paddr,
   input  wire  logic [31:0]              pwdata,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   // Observed target bus.
   input  wire  logic                     cyc_strobe,
   input  wire  trace_pkg::bus_cycle_type cyc_in,
   input  wire  logic                     blk_move,
   // Emulation control and interrupt.
   output logic                           emu_break,
   output logic                           trace_done,
   output logic                           irq
);
   import trace_pkg::*;

   // ==========================================================================
   // State.
   typedef struct packed {
      logic [2:0]                           strb_sync;
      bus_cycle_type                        cyc_s1;
      bus_cycle_type                        cyc_s2;
      logic                                 blk_s1;
      logic                                 blk_s2;
      logic                                 run;
      logic                                 qual_en;
      logic                                 qual_ne;
      logic                                 at_trig;
      match_pattern_type                    trig_pat;
      match_pattern_type                    qual_pat;
      logic [7:0]                           pass_cfg;
      logic [7:0]                           break_cfg;
      logic [9:0]                           pre_cfg;
      logic [3:0]                           log2_cfg;
      logic [2:0]                           irq_st;
      logic [2:0]                           irq_mask;
      logic [9:0]                           rd_index;
      trace_state_type                      state;
      logic [7:0]                           pass_run;
      logic [7:0]                           part;
      logic [9:0]                           wr_off;
      logic [10:0]                          remain;
      logic [8:0]                           done_cnt;
      logic [8:0]                           seq;
      logic [8:0]                           first_seq;
      logic                                 first_seen;
      logic [3:0]                           blk_cnt;
      logic [31:0]                          prdata;
      logic                                 pready;
      logic                                 pslverr;
      logic                                 brk;
      logic                                 done;
      logic                                 irq;
      trace_entry_type [MEM_DEPTH-1:0]      mem;
      snap_info_type [MAX_SNAPS-1:0]        info;
   } state_type;

   state_type q;
   state_type nxt;

   // ==========================================================================
   // Geometry helpers.
   function automatic logic [3:0] clamp_lg(input logic [3:0] lg);
      clamp_lg = (lg > LOG2_MAX) ? LOG2_MAX : lg;
   endfunction

   function automatic logic [10:0] snap_len(input logic [3:0] lg);
      snap_len = 11'h400 >> clamp_lg(lg);
   endfunction

   function automatic logic [9:0] mem_index(input logic [7:0] p, input logic [9:0] off,
                                            input logic [3:0] lg);
      mem_index = (10'(p) << (4'hA - clamp_lg(lg))) | off;
   endfunction

   function automatic logic [7:0] next_part(input logic [7:0] p, input logic [3:0] lg);
      logic [8:0] cnt;
      cnt = 9'h001 << clamp_lg(lg);
      next_part = 8'((9'(p) + 9'h001) & (cnt - 9'h001));
   endfunction

   // ==========================================================================
   // Pattern comparison.
   logic trig_addr_hit;
   logic trig_data_eq;
   logic trig_data_hit;
   logic trig_status_hit;
   logic qual_addr_hit;
   logic qual_data_eq;
   logic qual_data_hit;
   logic qual_status_hit;

   bus_pattern_match trig_match (
      .pattern    (q.trig_pat),
      .cycle      (q.cyc_s2),
      .addr_hit   (trig_addr_hit),
      .data_eq    (trig_data_eq),
      .data_hit   (trig_data_hit),
      .status_hit (trig_status_hit)
   );

   bus_pattern_match qual_match (
      .pattern    (q.qual_pat),
      .cycle      (q.cyc_s2),
      .addr_hit   (qual_addr_hit),
      .data_eq    (qual_data_eq),
      .data_hit   (qual_data_hit),
      .status_hit (qual_status_hit)
   );

   // ==========================================================================
   // Next state.
   always_comb begin
      logic            strobe;
      logic            match_evt;
      logic            trig_evt;
      logic            qual_ok;
      logic            store;
      logic            was_post;
      logic            last;
      logic [7:0]      p;
      logic [9:0]      off;
      logic [10:0]     len;
      logic [10:0]     pre_eff;
      logic [10:0]     rem;
      logic [8:0]      dc;
      logic [2:0]      ev;
      logic [2:0]      clr;
      logic            acc;
      logic [7:0]      rd_part;
      trace_entry_type rd_entry;
      logic [8:0]      sdiff;
      strobe    = 1'b0;
      match_evt = 1'b0;
      trig_evt  = 1'b0;
      qual_ok   = 1'b0;
      store     = 1'b0;
      was_post  = 1'b0;
      last      = 1'b0;
      p         = q.part;
      off       = q.wr_off;
      len       = snap_len(q.log2_cfg);
      pre_eff   = 11'h000;
      rem       = q.remain;
      dc        = q.done_cnt;
      ev        = 3'h0;
      clr       = 3'h0;
      acc       = 1'b0;
      rd_part   = 8'h00;
      rd_entry  = q.mem[q.rd_index];
      sdiff     = 9'h000;
      nxt       = q;

      // Observed pins pass two flip-flops before use.
      nxt.strb_sync = {q.strb_sync[1:0], cyc_strobe};
      nxt.cyc_s1    = cyc_in;
      nxt.cyc_s2    = q.cyc_s1;
      nxt.blk_s1    = blk_move;
      nxt.blk_s2    = q.blk_s1;
      strobe        = q.strb_sync[1] && !q.strb_sync[2];

      // Trigger with pass count, and the qualifier.
      if (!q.at_trig) begin
         pre_eff = (11'(q.pre_cfg) > len) ? len : 11'(q.pre_cfg);
      end
      match_evt = strobe && trig_addr_hit && trig_data_hit && trig_status_hit
                  && (q.state == ST_PRE || q.state == ST_POST);
      if (match_evt) begin
         if (q.pass_run + 8'h01 >= q.pass_cfg) begin
            trig_evt     = 1'b1;
            nxt.pass_run = 8'h00;
         end else begin
            nxt.pass_run = q.pass_run + 8'h01;
         end
      end
      qual_ok = qual_addr_hit && qual_status_hit
                && (!q.qual_pat.data_en || (q.qual_ne ? !qual_data_eq : qual_data_eq));
      store   = strobe && (!q.qual_en || qual_ok || trig_evt);

      unique case (q.state)
         ST_IDLE, ST_STOP: begin
         end
         ST_PRE, ST_POST: begin
            if (store) begin
               was_post = (q.state == ST_POST);
               last     = (9'(dc) + 9'h001) >= 9'(q.break_cfg);
               if (trig_evt && was_post && !last) begin
                  ev[IRQ_SNAP_BIT] = 1'b1;
                  dc               = q.done_cnt + 9'h001;
                  p                = next_part(q.part, q.log2_cfg);
                  off              = 10'h000;
                  nxt.seq          = q.seq + 9'h001;
                  nxt.info[p].seq  = q.seq + 9'h001;
                  was_post         = 1'b0;
               end
               nxt.mem[mem_index(p, off, q.log2_cfg)] = {trig_evt, q.cyc_s2};
               if (trig_evt) begin
                  ev[IRQ_TRIG_BIT]     = 1'b1;
                  nxt.info[p].last_pos = off;
                  if (!q.first_seen) begin
                     nxt.first_seen = 1'b1;
                     nxt.first_seq  = nxt.info[p].seq;
                  end
               end
               if (trig_evt && !was_post) begin
                  rem = len - pre_eff;
               end else if (was_post) begin
                  rem = q.remain - 11'h001;
               end
               off = (11'(off) == len - 11'h001) ? 10'h000 : off + 10'h001;
               nxt.state = (was_post || trig_evt) ? ST_POST : ST_PRE;
               if ((was_post || trig_evt) && rem == 11'h000) begin
                  ev[IRQ_SNAP_BIT] = 1'b1;
                  dc               = dc + 9'h001;
                  if (dc >= 9'(q.break_cfg)) begin
                     ev[IRQ_BREAK_BIT] = 1'b1;
                     nxt.brk           = 1'b1;
                     nxt.state         = ST_DRAIN;
                  end else begin
                     p               = next_part(p, q.log2_cfg);
                     off             = 10'h000;
                     nxt.seq         = nxt.seq + 9'h001;
                     nxt.info[p].seq = nxt.seq;
                     nxt.state       = ST_PRE;
                  end
               end
               nxt.part     = p;
               nxt.wr_off   = off;
               nxt.remain   = rem;
               nxt.done_cnt = dc;
            end
         end
         ST_DRAIN: begin
            if (strobe) begin
               if (q.cyc_s2.status == FETCH1_CODE) begin
                  nxt.state = ST_STOP;
                  nxt.done  = 1'b1;
               end else begin
                  if (store) begin
                     nxt.mem[mem_index(q.part, q.wr_off, q.log2_cfg)] = {1'b0, q.cyc_s2};
                     nxt.wr_off = (11'(q.wr_off) == len - 11'h001) ? 10'h000
                                                                  : q.wr_off + 10'h001;
                  end
                  if (q.blk_s2) begin
                     nxt.blk_cnt = q.blk_cnt + 4'h1;
                     if (q.blk_cnt + 4'h1 >= BLK_CUT) begin
                        nxt.state = ST_STOP;
                        nxt.done  = 1'b1;
                     end
                  end
               end
            end
         end
      endcase

      // APB: answer one cycle into the access phase; writes act at that edge.
      nxt.pready  = psel && !penable;
      acc         = psel && penable && q.pready;
      rd_part     = 8'(q.rd_index >> (4'hA - clamp_lg(q.log2_cfg)));
      sdiff       = q.info[rd_part].seq - q.first_seq;
      if (psel && !penable) begin
         nxt.pslverr = 1'b0;
         nxt.prdata  = 32'h0000_0000;
         unique case (paddr)
            REG_CTRL:       nxt.prdata = {28'h0, q.at_trig, q.qual_ne, q.qual_en, q.run};
            REG_TRIG_ADDR:  nxt.prdata = {q.trig_pat.addr_en, 7'h00, q.trig_pat.addr};
            REG_TRIG_DS:    nxt.prdata = {7'h00, q.trig_pat[24:0]};
            REG_QUAL_ADDR:  nxt.prdata = {q.qual_pat.addr_en, 7'h00, q.qual_pat.addr};
            REG_QUAL_DS:    nxt.prdata = {7'h00, q.qual_pat[24:0]};
            REG_PASS:       nxt.prdata = {24'h0, q.pass_cfg};
            REG_SNAP:       nxt.prdata = {12'h0, q.log2_cfg, 6'h0, q.pre_cfg};
            REG_BREAK:      nxt.prdata = {24'h0, q.break_cfg};
            REG_STATUS:     nxt.prdata = {q.part, 7'h0, q.done_cnt, 4'h0, q.first_seen,
                                          q.done, q.brk,
                                          (q.state == ST_PRE || q.state == ST_POST
                                           || q.state == ST_DRAIN)};
            REG_IRQ_STATUS: nxt.prdata = {29'h0, q.irq_st};
            REG_IRQ_MASK:   nxt.prdata = {29'h0, q.irq_mask};
            REG_INDEX:      nxt.prdata = {22'h0, q.rd_index};
            REG_TRACE_LO:   nxt.prdata = {11'h0, rd_entry.trig, rd_entry.cyc.status,
                                          rd_entry.cyc.data};
            REG_TRACE_ADDR: nxt.prdata = {8'h00, rd_entry.cyc.addr};
            REG_SNAP_INFO:  nxt.prdata = {{7{sdiff[8]}}, sdiff, 6'h00,
                                          q.info[rd_part].last_pos};
            default:        nxt.pslverr = 1'b1;
         endcase
      end
      if (acc && !pwrite && paddr == REG_TRACE_ADDR) begin
         nxt.rd_index = q.rd_index + 10'h001;
      end
      if (acc && pwrite) begin
         unique case (paddr)
            REG_CTRL: begin
               nxt.run     = pwdata[CTRL_RUN_BIT];
               nxt.qual_en = pwdata[CTRL_QUAL_EN_BIT];
               nxt.qual_ne = pwdata[CTRL_QUAL_NE_BIT];
               nxt.at_trig = pwdata[CTRL_AT_TRIG_BIT];
               nxt.state   = pwdata[CTRL_RUN_BIT] ? ST_PRE : ST_IDLE;
               nxt.pass_run   = 8'h00;
               nxt.part       = 8'h00;
               nxt.wr_off     = 10'h000;
               nxt.remain     = 11'h000;
               nxt.done_cnt   = 9'h000;
               nxt.seq        = 9'h000;
               nxt.info[0]    = '0;
               nxt.first_seq  = 9'h000;
               nxt.first_seen = 1'b0;
               nxt.blk_cnt    = 4'h0;
               nxt.brk        = 1'b0;
               nxt.done       = 1'b0;
            end
            REG_TRIG_ADDR: begin
               nxt.trig_pat.addr_en = pwdata[ADDR_EN_BIT];
               nxt.trig_pat.addr    = pwdata[23:0];
            end
            REG_TRIG_DS:    nxt.trig_pat[24:0] = pwdata[DS_DATA_EN_BIT:0];
            REG_QUAL_ADDR: begin
               nxt.qual_pat.addr_en = pwdata[ADDR_EN_BIT];
               nxt.qual_pat.addr    = pwdata[23:0];
            end
            REG_QUAL_DS:    nxt.qual_pat[24:0] = pwdata[DS_DATA_EN_BIT:0];
            REG_PASS:       nxt.pass_cfg = pwdata[7:0];
            REG_SNAP: begin
               nxt.pre_cfg  = pwdata[9:0];
               nxt.log2_cfg = pwdata[SNAP_LOG2_LSB +: 4];
            end
            REG_BREAK:      nxt.break_cfg = pwdata[7:0];
            REG_IRQ_STATUS: clr = pwdata[2:0];
            REG_IRQ_MASK:   nxt.irq_mask = pwdata[2:0];
            REG_INDEX:      nxt.rd_index = pwdata[9:0];
            default: begin
            end
         endcase
      end

      // Interrupt: a new event wins over a clear in the same cycle.
      nxt.irq_st = (q.irq_st & ~clr) | ev;
      nxt.irq    = |(nxt.irq_st & nxt.irq_mask);
   end

   // ==========================================================================
   // Registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q           <= '0;
         q.pass_cfg  <= PASS_RST;
         q.break_cfg <= BREAK_RST;
         q.log2_cfg  <= LOG2_RST;
      end else begin
         q <= nxt;
      end
   end

   assign prdata     = q.prdata;
   assign pready     = q.pready;
   assign pslverr    = q.pslverr;
   assign emu_break  = q.brk;
   assign trace_done = q.done;
   assign irq        = q.irq;

endmodule

`default_nettype wire

// file: logic/trace_pkg.sv
/*
 * Shared definitions of the bus trace and trigger block: register offsets,
 * field positions, reset values, sizes and the types that carry bus cycles,
 * match patterns and trace entries.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package trace_pkg;

   // ==========================================================================
   // Register offsets (byte addresses on APB).
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_TRIG_ADDR  = 8'h04;
   localparam logic [7:0] REG_TRIG_DS    = 8'h08;
   localparam logic [7:0] REG_QUAL_ADDR  = 8'h0C;
   localparam logic [7:0] REG_QUAL_DS    = 8'h10;
   localparam logic [7:0] REG_PASS       = 8'h14;
   localparam logic [7:0] REG_SNAP       = 8'h18;
   localparam logic [7:0] REG_BREAK      = 8'h1C;
   localparam logic [7:0] REG_STATUS     = 8'h20;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h24;
   localparam logic [7:0] REG_IRQ_MASK   = 8'h28;
   localparam logic [7:0] REG_INDEX      = 8'h2C;
   localparam logic [7:0] REG_TRACE_LO   = 8'h30;
   localparam logic [7:0] REG_TRACE_ADDR = 8'h34;
   localparam logic [7:0] REG_SNAP_INFO  = 8'h38;

   // ==========================================================================
   // Field positions.
   localparam int CTRL_RUN_BIT     = 0;
   localparam int CTRL_QUAL_EN_BIT = 1;
   localparam int CTRL_QUAL_NE_BIT = 2;
   localparam int CTRL_AT_TRIG_BIT = 3;
   localparam int ADDR_EN_BIT      = 31;
   localparam int DS_STATUS_LSB    = 16;
   localparam int DS_CARE_LSB      = 20;
   localparam int DS_DATA_EN_BIT   = 24;
   localparam int SNAP_LOG2_LSB    = 16;
   localparam int IRQ_TRIG_BIT     = 0;
   localparam int IRQ_SNAP_BIT     = 1;
   localparam int IRQ_BREAK_BIT    = 2;

   // ==========================================================================
   // Reset values, sizes and codes.
   localparam logic [7:0] PASS_RST        = 8'h01;
   localparam logic [7:0] BREAK_RST       = 8'h01;
   localparam logic [3:0] LOG2_RST        = 4'h0;
   localparam logic [3:0] LOG2_MAX        = 4'h8;
   localparam logic [3:0] DATA_CYCLE_CODE = 4'h8;
   localparam logic [3:0] BLOCK_MOVE_CUT  = 4'h4;
   localparam int         MEM_DEPTH       = 1024;
   localparam int         MAX_SNAPS       = 256;

   // ==========================================================================
   // Carriers.
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] data;
      logic [3:0]  status;
   } bus_cycle_type;

   typedef struct packed {
      logic        addr_en;
      logic [23:0] addr;
      logic        data_en;
      logic [3:0]  care;
      logic [3:0]  status;
      logic [15:0] data;
   } match_pattern_type;

   typedef struct packed {
      logic          trig;
      bus_cycle_type cyc;
   } trace_entry_type;

   typedef struct packed {
      logic [8:0] seq;
      logic [9:0] last_pos;
   } snap_info_type;

   typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_POST, ST_DRAIN, ST_STOP} trace_state_type;

endpackage

// file: verif/target_bus_model.sv
/* Target processor bus model, one cycle per call. Assumes the bench clock. */
`timescale 1ns/10ps
`default_nettype none
module target_bus_model (
   input  wire logic                     pclk,
   output var  logic                     cyc_strobe, blk_move,
   output var  trace_pkg::bus_cycle_type cyc_in
);
   initial {cyc_strobe, blk_move, cyc_in} = '0;
   task automatic set_blk(input logic b);
      blk_move <= b;
   endtask
   // Lines settle two edges ahead of the strobe and are scrambled after it.
   task automatic run_cycle(input logic [23:0] a, input logic [15:0] d, input logic [3:0] s);
      cyc_in <= {a, d, s};
      repeat (2) @(posedge pclk);
      cyc_strobe <= 1'h1;
      repeat (4) @(posedge pclk);
      cyc_strobe <= 1'h0;
      cyc_in <= ~cyc_in;
      repeat (3) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
/* Bench of the trace block over APB and the bus model. Assumes trace_pkg. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import trace_pkg::*;
   logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic          emu_break, trace_done, irq, cyc_strobe, blk_move;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata;
   bus_cycle_type cyc_in;
   int            n_mismatch = 0, n_tests = 0, k;
   bus_trace_trigger_snapshot uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .cyc_strobe, .cyc_in, .blk_move, .emu_break, .trace_done, .irq);
   target_bus_model tgt (.pclk, .cyc_strobe, .cyc_in, .blk_move);
   initial begin
      pclk = 1'h0;
      forever #4 pclk = ~pclk;
   end
   task automatic close_out();
      $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) n_mismatch++;
      if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
   endtask
   // One transfer; read data and error are taken at the pready edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, exp);
      int i;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, d};
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'h1 && penable === 1'h1) break;
         penable <= 1'h1;
      end
      check("pready", 32'h1, {31'h0, pready});
      if (pready !== 1'h1) close_out();
      check("pslverr", {31'h0, a > 8'h38}, {31'h0, pslverr});
      if (!wr) check("prdata", exp, prdata);
      {psel, penable} <= 2'h0;
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h0, REG_PASS, 32'h0, {24'h0, PASS_RST});
      apb(1'h0, 8'h3C, 32'h0, 32'h0);
      apb(1'h1, REG_TRIG_ADDR, 32'h8000_0014, 32'h0);
      apb(1'h1, REG_TRIG_DS, 32'h0088_0000, 32'h0);
      apb(1'h1, REG_PASS, 32'h2, 32'h0);
      apb(1'h1, REG_SNAP, 32'h0007_0004, 32'h0);
      apb(1'h1, REG_IRQ_MASK, 32'h7, 32'h0);
      apb(1'h1, REG_CTRL, 32'h1, 32'h0);
      tgt.run_cycle(24'h14, 16'h1000, 4'h2);
      tgt.run_cycle(24'h14, 16'h1001, 4'h9);
      tgt.run_cycle(24'h14, 16'h1002, 4'h9);
      for (k = 0; k < 4; k++) begin
         check("emu_break", 32'h0, {31'h0, emu_break});
         tgt.run_cycle(24'h30, 16'h2000 + 16'(k), 4'h1);
      end
      check("irq", 32'h1, {31'h0, irq});
      apb(1'h0, REG_IRQ_STATUS, 32'h0, 32'h7);
      tgt.run_cycle(24'h40, 16'h3000, 4'hC);
      check("flags", 32'h3, {30'h0, emu_break, trace_done});
      apb(1'h1, REG_INDEX, 32'h2, 32'h0);
      apb(1'h0, REG_TRACE_LO, 32'h0, 32'h0019_1002);
      apb(1'h0, REG_TRACE_ADDR, 32'h0, 32'h14);
      apb(1'h0, REG_TRACE_LO, 32'h0, 32'h0001_2000);
      apb(1'h1, REG_IRQ_STATUS, 32'h7, 32'h0);
      apb(1'h1, REG_CTRL, 32'h0, 32'h0);
      @(posedge pclk);
      check("pins", 32'h0, {29'h0, irq, emu_break, trace_done});
      apb(1'h1, REG_BREAK, 32'h2, 32'h0);
      apb(1'h1, REG_PASS, 32'h1, 32'h0);
      apb(1'h1, REG_SNAP, 32'h0008_0004, 32'h0);
      apb(1'h1, REG_QUAL_DS, 32'h0100_5555, 32'h0);
      apb(1'h1, REG_CTRL, 32'hB, 32'h0);
      tgt.run_cycle(24'h14, 16'h5555, 4'h9);
      apb(1'h0, REG_STATUS, 32'h0, 32'h0000_0009);
      tgt.run_cycle(24'h20, 16'h1234, 4'h1);
      tgt.run_cycle(24'h20, 16'h5555, 4'h1);
      tgt.run_cycle(24'h14, 16'h5555, 4'h9);
      apb(1'h0, REG_STATUS, 32'h0, 32'h0100_0109);
      apb(1'h1, REG_INDEX, 32'h1, 32'h0);
      apb(1'h0, REG_TRACE_LO, 32'h0, 32'h0001_5555);
      apb(1'h1, REG_INDEX, 32'h4, 32'h0);
      apb(1'h0, REG_TRACE_LO, 32'h0, 32'h0019_5555);
      apb(1'h0, REG_SNAP_INFO, 32'h0, 32'h0001_0000);
      for (k = 0; k < 4; k++) begin
         check("emu_break", 32'h0, {31'h0, emu_break});
         tgt.run_cycle(24'h20, 16'h5555, 4'h1);
      end
      check("emu_break", 32'h1, {31'h0, emu_break});
      tgt.set_blk(1'h1);
      for (k = 0; k < 4; k++) begin
         check("trace_done", 32'h0, {31'h0, trace_done});
         tgt.run_cycle(24'h20, 16'h5555, 4'h1);
      end
      check("trace_done", 32'h1, {31'h0, trace_done});
      close_out();
   end
endmodule
`default_nettype wire

// file: verif/trace_monitor.sv
/* Port checker of the trace block. Assumes binding to its top module. */
`timescale 1ns/10ps
`default_nettype none
module trace_monitor (
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        cyc_strobe, emu_break, trace_done
);
   wire logic ctrl_wr = psel && penable && pready && pwrite && paddr == 8'h00;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready late");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_unmapped: assert property (pready && paddr > 8'h38 |-> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
   a_err_mapped: assert property (pready && paddr <= 8'h38 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped refused");
   a_break_holds: assert property (emu_break && !ctrl_wr |=> emu_break)
      else $error("break dropped");
   a_done_with_break: assert property (trace_done |-> emu_break)
      else $error("done without break");
   a_break_after_cycle: assert property
      ($rose(emu_break) |-> $past(cyc_strobe, 3) && !$past(cyc_strobe, 4))
      else $error("break without cycle");
   a_ctrl_clears: assert property (ctrl_wr |=> !emu_break && !trace_done)
      else $error("flags not cleared");
endmodule
bind bus_trace_trigger_snapshot trace_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite,
   .pready, .pslverr, .paddr, .prdata, .cyc_strobe, .emu_break, .trace_done);
`default_nettype wire
